// *** common/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;
	localparam logic [7:0] ADDR_CLOCK_DIVIDER = 8'hf2;
	localparam logic [7:0] ADDR_CONV_CONTROL  = 8'hf3;
	localparam logic [7:0] ADDR_RESULT_LOW    = 8'hf4;
	localparam logic [7:0] ADDR_RESULT_HIGH   = 8'hf5;
	localparam logic [7:0] ADDR_PIN_ROUTING   = 8'hf6;
	localparam logic [7:0] RESET_BYTE         = 8'h00;
	localparam int BIT_PRECISION = 6;
	localparam int BIT_ON        = 5;
	localparam int BIT_DONE      = 4;
	localparam int BIT_START     = 3;
	localparam int CONV_PERIODS  = 11;
	localparam int RESULT_BITS   = 10;
	localparam logic [5:0] DIVISOR_ZERO_HALF = 6'h20;
	localparam logic [9:0] RESULT_FULL  = 10'h3ff;
	localparam logic [9:0] RESULT_EMPTY = 10'h000;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SAMPLE,
		ST_DECIDE
	} conv_state_t;
endpackage

// *** rtl/conv_tick_gen.sv ***
`timescale 1ns/1ps
// makes one tick every 2*P clocks of the peripheral clock, 64 when P is zero
module conv_tick_gen
	import adc_ctrl_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       run_i,
	input  wire logic [4:0] divisor_i,
	output logic            tick_o
);
	logic [5:0] count;
	logic [5:0] limit;

	always_comb begin
		if (divisor_i == 5'h00) begin
			limit = DIVISOR_ZERO_HALF + (DIVISOR_ZERO_HALF - 6'h01);
		end else begin
			limit = {divisor_i, 1'b0} - 6'h01;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count  <= 6'h00;
			tick_o <= 1'b0;
		end else if (!run_i) begin
			// starts at one so the registered tick lands a full period after the start
			count  <= 6'h01;
			tick_o <= 1'b0;
		end else if (count >= limit) begin
			count  <= 6'h00;
			tick_o <= 1'b1;
		end else begin
			count  <= count + 6'h01;
			tick_o <= 1'b0;
		end
	end
endmodule

// *** rtl/sar_decider.sv ***
`timescale 1ns/1ps
// successive approximation register: one bit decided per step, msb first
module sar_decider
	import adc_ctrl_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   arst_n_i,
	input  wire logic                   load_i,
	input  wire logic                   step_i,
	input  wire logic                   comp_above_i,
	output logic [RESULT_BITS-1:0]      trial_o,
	output logic [RESULT_BITS-1:0]      result_o
);
	logic [RESULT_BITS-1:0] probe;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			probe    <= '0;
			result_o <= '0;
		end else if (load_i) begin
			probe    <= {1'b1, {(RESULT_BITS-1){1'b0}}};
			result_o <= '0;
		end else if (step_i && probe != '0) begin
			if (comp_above_i) begin
				result_o <= result_o | probe;
			end
			probe <= probe >> 1;
		end
	end

	assign trial_o = result_o | probe;
endmodule

// *** rtl/adc_conversion_control.sv ***
`timescale 1ns/1ps
// How it works
// - writing start bit 3 begins one conversion on the selected channel
// - hardware clears the start bit when the conversion ends; it reads as busy
// - done flag bit 4 sets when results valid; only software clears it
// - interrupt request while done flag and enable are both set
// - channel select bits 2..0 route analog input N to the converter
// - full scale codes 3FFh, bottom 000h, linear between, from comparator
// - converter tick every 2*P peripheral clocks, every 64 when P is zero
// - against cpu clock divide 4*P standard, 2*P double speed
// - clearing enable bit 5 puts converter in standby; setting runs it
// - precision bit 6 at start halts the cpu during that conversion
// - each routing bit hands its port pin to the converter when set
// - result bits 9..2 in high register, bits 1..0 in low register
// - a conversion lasts 11 ticks: one sample then ten bit decisions
// - a start on a channel whose routing bit is clear does nothing
// - in precision mode only conversion done resumes the cpu
module adc_conversion_control
	import adc_ctrl_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic [7:0] addr_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       irq_enable_i,
	input  wire logic       double_speed_clock_i,
	input  wire logic       comp_above_i,
	output logic [7:0]      rdata_o,
	output logic            irq_o,
	output logic [2:0]      channel_select_o,
	output logic [7:0]      pin_route_bits_o,
	output logic            converter_on_o,
	output logic            sample_hold_o,
	output logic [9:0]      trial_code_o,
	output logic            cpu_halt_o,
	output logic            busy_o
);
	logic [4:0]        clock_divisor;
	logic [7:0]        pin_routing;
	logic [2:0]        channel_select;
	logic              converter_on;
	logic              precision_cpu_halt;
	logic              conv_done_flag;
	logic              start_conv_bit;
	logic [9:0]        result;
	logic              halted;
	conv_state_t       state;
	logic [3:0]        periods;
	logic              tick;
	logic              load;
	logic              finish;
	logic [9:0]        trial;
	logic [9:0]        sar_result;
	logic              ctrl_wr;
	logic              start_req;
	logic              raw_tick;
	logic              tick_phase;
	logic [6:0]        tick_gap;
	logic [6:0]        gap_limit;

	assign ctrl_wr   = wr_i && addr_i == ADDR_CONV_CONTROL;
	// accept only when idle, enabled and the channel pin is routed
	assign start_req = ctrl_wr && wdata_i[BIT_START] && state == ST_IDLE && converter_on
		&& pin_routing[wdata_i[2:0]];
	assign load      = start_req;
	assign finish    = state == ST_DECIDE && tick && periods == 4'(CONV_PERIODS - 1);

	// standard mode: cpu clock runs at twice the peripheral rate, so every second tick counts unless the divisor is zero
	assign tick = raw_tick && (double_speed_clock_i || clock_divisor == 5'h00 || tick_phase);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tick_phase <= 1'b0;
		end else if (state == ST_IDLE) begin
			tick_phase <= 1'b0;
		end else if (raw_tick) begin
			tick_phase <= !tick_phase;
		end
	end

	// cycles since the last counted tick, for the spacing check
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tick_gap <= 7'h00;
		end else if (state == ST_IDLE || tick) begin
			tick_gap <= 7'h00;
		end else begin
			tick_gap <= tick_gap + 7'h01;
		end
	end

	always_comb begin
		if (clock_divisor == 5'h00) begin
			gap_limit = 7'(DIVISOR_ZERO_HALF) + 7'(DIVISOR_ZERO_HALF) - 7'h01;
		end else if (double_speed_clock_i) begin
			gap_limit = {1'b0, clock_divisor, 1'b0} - 7'h01;
		end else begin
			gap_limit = {clock_divisor, 2'b00} - 7'h01;
		end
	end

	conv_tick_gen u_tick (
		.clk_i     (clk_i),
		.arst_n_i  (arst_n_i),
		.run_i     (state != ST_IDLE),
		.divisor_i (clock_divisor),
		.tick_o    (raw_tick)
	);

	sar_decider u_sar (
		.clk_i        (clk_i),
		.arst_n_i     (arst_n_i),
		.load_i       (load),
		.step_i       (state == ST_DECIDE && tick),
		.comp_above_i (comp_above_i),
		.trial_o      (trial),
		.result_o     (sar_result)
	);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			clock_divisor <= 5'h00;
			pin_routing   <= RESET_BYTE;
		end else if (wr_i && addr_i == ADDR_CLOCK_DIVIDER) begin
			clock_divisor <= wdata_i[4:0];
		end else if (wr_i && addr_i == ADDR_PIN_ROUTING) begin
			pin_routing <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			channel_select     <= 3'h0;
			converter_on       <= 1'b0;
			precision_cpu_halt <= 1'b0;
		end else if (ctrl_wr) begin
			channel_select     <= wdata_i[2:0];
			converter_on       <= wdata_i[BIT_ON];
			precision_cpu_halt <= wdata_i[BIT_PRECISION];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state          <= ST_IDLE;
			periods        <= 4'h0;
			start_conv_bit <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_req) begin
						state          <= ST_SAMPLE;
						start_conv_bit <= 1'b1;
						periods        <= 4'h0;
					end
				end
				ST_SAMPLE: begin
					if (tick) begin
						state   <= ST_DECIDE;
						periods <= 4'h1;
					end
				end
				ST_DECIDE: begin
					if (finish) begin
						state          <= ST_IDLE;
						start_conv_bit <= 1'b0;
					end else if (tick) begin
						periods <= periods + 4'h1;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			result <= RESULT_EMPTY;
		end else if (finish) begin
			result <= sar_result | (comp_above_i ? 10'h001 : 10'h000);
		end
	end

	// set wins over a software clear in the same cycle
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			conv_done_flag <= 1'b0;
		end else if (finish) begin
			conv_done_flag <= 1'b1;
		end else if (ctrl_wr && !wdata_i[BIT_DONE]) begin
			conv_done_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			halted <= 1'b0;
		end else if (start_req && wdata_i[BIT_PRECISION]) begin
			halted <= 1'b1;
		end else if (finish) begin
			halted <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_o            <= 1'b0;
			channel_select_o <= 3'h0;
			pin_route_bits_o <= RESET_BYTE;
			converter_on_o   <= 1'b0;
			sample_hold_o    <= 1'b0;
			trial_code_o     <= RESULT_EMPTY;
			cpu_halt_o       <= 1'b0;
			busy_o           <= 1'b0;
		end else begin
			irq_o            <= conv_done_flag && irq_enable_i;
			channel_select_o <= channel_select;
			pin_route_bits_o <= pin_routing;
			converter_on_o   <= converter_on;
			sample_hold_o    <= state == ST_SAMPLE;
			trial_code_o     <= trial;
			cpu_halt_o       <= halted;
			busy_o           <= start_conv_bit;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= RESET_BYTE;
		end else if (rd_i) begin
			if (addr_i == ADDR_CLOCK_DIVIDER) begin
				rdata_o <= {3'h0, clock_divisor};
			end else if (addr_i == ADDR_CONV_CONTROL) begin
				rdata_o <= {1'b0, precision_cpu_halt, converter_on, conv_done_flag,
					start_conv_bit, channel_select};
			end else if (addr_i == ADDR_RESULT_LOW) begin
				rdata_o <= {6'h00, result[1:0]};
			end else if (addr_i == ADDR_RESULT_HIGH) begin
				rdata_o <= result[9:2];
			end else if (addr_i == ADDR_PIN_ROUTING) begin
				rdata_o <= pin_routing;
			end else begin
				rdata_o <= RESET_BYTE;
			end
		end
	end

	a_start_sets_busy: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		start_req |=> start_conv_bit && state == ST_SAMPLE)
		else $error("start did not begin a conversion");
	a_busy_clears_end: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		finish |=> !start_conv_bit && conv_done_flag)
		else $error("start bit not cleared at end");
	a_done_sticky: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		conv_done_flag && !ctrl_wr |=> conv_done_flag)
		else $error("done flag dropped without software clear");
	a_irq_follows: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		conv_done_flag && irq_enable_i |=> irq_o)
		else $error("interrupt not raised");
	a_channel_out: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ctrl_wr |=> ##1 channel_select_o == $past(wdata_i[2:0], 2))
		else $error("channel select not routed");
	a_unrouted_ignored: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ctrl_wr && wdata_i[BIT_START] && !pin_routing[wdata_i[2:0]] && state == ST_IDLE |=> state == ST_IDLE)
		else $error("unrouted start was accepted");
	a_no_restart: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ctrl_wr && wdata_i[BIT_START] && state != ST_IDLE |-> !load)
		else $error("start accepted during conversion");
	a_halt_clears: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		finish |=> ##1 !cpu_halt_o)
		else $error("cpu not resumed at end");
	a_standby_out: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ctrl_wr && !wdata_i[BIT_ON] |=> ##1 !converter_on_o)
		else $error("standby not entered");
	a_standby_refuses: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ctrl_wr && wdata_i[BIT_START] && !converter_on |-> !load)
		else $error("start accepted in standby");
	a_halt_on_start: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		start_req && wdata_i[BIT_PRECISION] |=> ##1 cpu_halt_o)
		else $error("cpu not halted for precision conversion");
	a_result_stable: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!finish |=> $stable(result))
		else $error("result changed outside end of conversion");
	a_done_needs_end: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!conv_done_flag && !finish |=> !conv_done_flag)
		else $error("done flag set without end of conversion");
	a_busy_mirror: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		busy_o == $past(start_conv_bit))
		else $error("busy output does not follow start bit");
	a_irq_quiet: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!conv_done_flag |=> !irq_o)
		else $error("interrupt raised without done flag");
	a_tick_spacing: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		tick && state != ST_IDLE |-> tick_gap == gap_limit)
		else $error("converter tick spacing wrong");
	a_sample_ends: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		state == ST_SAMPLE && tick |=> state == ST_DECIDE ##1 !sample_hold_o)
		else $error("sample period did not end after one tick");
	a_high_byte: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		rd_i && addr_i == ADDR_RESULT_HIGH |=> rdata_o == $past(result[9:2]))
		else $error("high result byte wrong");
	a_low_byte: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		rd_i && addr_i == ADDR_RESULT_LOW |=> rdata_o == {6'h00, $past(result[1:0])})
		else $error("low result byte wrong");
	a_route_out: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		wr_i && addr_i == ADDR_PIN_ROUTING |=> ##1 pin_route_bits_o == $past(wdata_i, 2))
		else $error("pin routing not passed out");
endmodule

// *** test/analog_front_model.sv ***
`timescale 1ns/1ps
// behavioural mux, sample-and-hold and comparator in front of the converter
module analog_front_model (
	input  wire logic            clk_i,
	input  wire logic [7:0][9:0] level_i,
	input  wire logic [2:0]      channel_select_i,
	input  wire logic            converter_on_i,
	input  wire logic            sample_hold_i,
	input  wire logic [9:0]      trial_code_i,
	output logic                 comp_above_o
);
	logic [9:0] held  = 10'h000;
	logic       noise = 1'b0;
	always_ff @(posedge clk_i) begin
		noise <= ~noise;
		if (sample_hold_i) begin
			held <= level_i[channel_select_i];
		end
	end
	// in standby the comparator output is meaningless, so it wanders
	assign comp_above_o = converter_on_i ? (held >= trial_code_i) : noise;
endmodule

// *** test/adc_conversion_control_tb.sv ***
`timescale 1ns/1ps
module adc_conversion_control_tb;
	import adc_ctrl_pkg::*;
	logic            clk_i;
	logic            arst_n_i;
	logic [7:0]      addr_i;
	logic            wr_i;
	logic            rd_i;
	logic [7:0]      wdata_i;
	logic            irq_enable_i;
	logic            double_speed_clock_i;
	logic            comp_above_i;
	logic [7:0]      rdata_o;
	logic            irq_o;
	logic [2:0]      channel_select_o;
	logic [7:0]      pin_route_bits_o;
	logic            converter_on_o;
	logic            sample_hold_o;
	logic [9:0]      trial_code_o;
	logic            cpu_halt_o;
	logic            busy_o;
	logic [7:0][9:0] levels;
	int              n_errors;
	int              total_checks;

	adc_conversion_control i_adc_conversion_control (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
		.wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .irq_enable_i(irq_enable_i),
		.double_speed_clock_i(double_speed_clock_i), .comp_above_i(comp_above_i), .rdata_o(rdata_o),
		.irq_o(irq_o), .channel_select_o(channel_select_o), .pin_route_bits_o(pin_route_bits_o),
		.converter_on_o(converter_on_o), .sample_hold_o(sample_hold_o), .trial_code_o(trial_code_o),
		.cpu_halt_o(cpu_halt_o), .busy_o(busy_o));

	analog_front_model i_analog_front_model (.clk_i(clk_i), .level_i(levels), .channel_select_i(channel_select_o),
		.converter_on_i(converter_on_o), .sample_hold_i(sample_hold_o), .trial_code_i(trial_code_o),
		.comp_above_o(comp_above_i));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		addr_i = a;
		wdata_i = d;
		wr_i = 1'b1;
		@(posedge clk_i);
		#1;
		wr_i = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		#1;
		addr_i = a;
		rd_i = 1'b1;
		@(posedge clk_i);
		#1;
		rd_i = 1'b0;
		d = rdata_o;
	endtask

	task automatic refused(input logic [7:0] ctl);
		wr(ADDR_CONV_CONTROL, ctl);
		repeat (3) @(posedge clk_i);
		#1;
		check("busy_refused", busy_o, 0);
	endtask

	task automatic run_conv(input logic [2:0] ch, input logic [4:0] p, input logic ds, input logic en,
		input logic prec);
		int         per;
		int         nb;
		int         nsh;
		logic [7:0] hi;
		logic [7:0] lo;
		logic [7:0] ctl;
		per = (p == 0) ? 64 : (ds ? 2 * p : 4 * p);
		// the refused restart write spans the first two busy cycles
		nb = 2;
		nsh = 2;
		irq_enable_i = en;
		double_speed_clock_i = ds;
		wr(ADDR_CLOCK_DIVIDER, {3'h0, p});
		wr(ADDR_CONV_CONTROL, {1'b0, prec, 2'b10, 1'b1, ch});
		@(posedge clk_i);
		#1;
		check("channel", channel_select_o, ch);
		check("halt", cpu_halt_o, prec);
		wr(ADDR_CONV_CONTROL, {1'b0, prec, 2'b10, 1'b1, ch});
		while (busy_o === 1'b1 && nb < 2000) begin
			nb++;
			nsh += int'(sample_hold_o);
			@(posedge clk_i);
			#1;
		end
		check("conv_len", nb >= 11 * per && nb <= 12 * per + 4, 1);
		check("sample_len", nsh, per);
		check("trial_end", trial_code_o, levels[ch]);
		repeat (2) @(posedge clk_i);
		#1;
		check("irq", irq_o, en);
		check("halt_end", cpu_halt_o, 0);
		rd(ADDR_CONV_CONTROL, ctl);
		check("control", ctl & 8'h7f, {1'b0, prec, 2'b11, 1'b0, ch});
		rd(ADDR_RESULT_HIGH, hi);
		rd(ADDR_RESULT_LOW, lo);
		check("result", {hi, lo[1:0]}, levels[ch]);
		wr(ADDR_CONV_CONTROL, {4'h2, 1'b0, ch});
		repeat (2) @(posedge clk_i);
		#1;
		check("irq_clear", irq_o, 0);
	endtask

	initial begin
		logic [7:0] d;
		n_errors = 0;
		total_checks = 0;
		arst_n_i = 1'b0;
		addr_i = 8'h00;
		wr_i = 1'b0;
		rd_i = 1'b0;
		wdata_i = 8'h00;
		irq_enable_i = 1'b0;
		double_speed_clock_i = 1'b0;
		levels = {10'h1ff, 10'h200, 10'h3fe, 10'h001, 10'h15a, 10'h2a5, 10'h000, 10'h3ff};
		repeat (16) @(posedge clk_i);
		#1;
		arst_n_i = 1'b1;
		for (int a = 8'hf0; a <= 8'hf6; a++) begin
			rd(a[7:0], d);
			check("reset_value", d, 0);
		end
		wr(ADDR_PIN_ROUTING, 8'h01);
		wr(ADDR_CONV_CONTROL, 8'h20);
		@(posedge clk_i);
		#1;
		check("converter_on", converter_on_o, 1);
		// settling time after enabling the converter
		repeat (20) @(posedge clk_i);
		refused(8'h2a);
		wr(ADDR_PIN_ROUTING, 8'hff);
		rd(ADDR_PIN_ROUTING, d);
		check("routing", {d, pin_route_bits_o}, 16'hffff);
		for (int ch = 0; ch < 8; ch++) begin
			run_conv(ch[2:0], ch[4:0], ch[0], ch[1], 1'b0);
		end
		run_conv(3'h3, 5'h1f, 1'b0, 1'b1, 1'b1);
		wr(ADDR_RESULT_HIGH, 8'hff);
		rd(ADDR_RESULT_HIGH, d);
		check("high_read_only", d, levels[3][9:2]);
		wr(ADDR_CONV_CONTROL, 8'h00);
		repeat (2) @(posedge clk_i);
		#1;
		check("standby", converter_on_o, 0);
		refused(8'h08);
		results();
	end

	initial begin
		#300000;
		n_errors++;
		results();
	end
endmodule
